// ### hw/tbr_pkg.sv
// Overview of operation
// - Master 80 MHz from oscillator or loop.
// - 20 MHz is master divided by four.
// - 100 kHz is 20 MHz divided by 200.
// - Counters choose 80M, 20M or 100k source.
// - Analog timing uses 20M, optionally 100k.
// - Reference from bus lines, backplane clock, star.
// - Selected reference feeds the loop for timebases.
// - 10 MHz reference divided from oscillator always.
// - 10 MHz reference drivable onto any bus line.
// - Initiator drives reference; all boards select it.
// - Backplane clock chosen as reference by all.
// - Star line clock chosen as reference by targets.
// - Shared start trigger plus equal rates synchronise.
// - Bus terminals bidirectional with selectable output source.
// - Convert and output sample clocks driven inverted.
// - Bus inputs routable to all timing destinations.
// - Per destination polarity and edge/level choice.
// - Routing takes bus, terminal, star inputs; onboard signals only drive bus lines.
package tbr_pkg;

   localparam int BUS_LINES = 8;
   localparam int PFT_LINES = 6;
   localparam int NUM_SRC   = 25;
   localparam int NUM_DEST  = 25;
   localparam int NUM_CTR   = 2;

   localparam int MASTER_MHZ   = 80;
   localparam int TB20_MHZ     = 20;
   localparam int REF10_MHZ    = 10;
   localparam int DIV_20M      = MASTER_MHZ / TB20_MHZ;
   localparam int DIV_100K     = 200;
   localparam int REF10_HALF   = MASTER_MHZ / REF10_MHZ / 2;

   // Reference selection codes
   localparam logic [3:0] EXT_BUS0  = 4'h0;
   localparam logic [3:0] EXT_CLK10 = 4'h8;
   localparam logic [3:0] EXT_STAR  = 4'h9;

   // Counter source selection codes
   localparam logic [1:0] CSRC_80M  = 2'h0;
   localparam logic [1:0] CSRC_20M  = 2'h1;
   localparam logic [1:0] CSRC_100K = 2'h2;

   // Output source indices into the internal signal vector
   localparam int OSRC_AI_START   = 0;
   localparam int OSRC_AI_REF     = 1;
   localparam int OSRC_AI_CONV    = 2;
   localparam int OSRC_AI_SAMP    = 3;
   localparam int OSRC_AO_SAMP    = 4;
   localparam int OSRC_AO_START   = 5;
   localparam int OSRC_AO_PAUSE   = 6;
   localparam int OSRC_REF10      = 7;
   localparam int OSRC_CTR0       = 8;
   localparam int OSRC_CHANGE_DET = 16;
   localparam int OSRC_ANA_CMP    = 17;
   localparam int OSRC_FREQUENCY_OUTPUT   = 18;
   localparam int OSRC_PFT0       = 19;

   // Input source codes: 0..7 bus lines, 8..13 terminals, 14 star, 15 none
   localparam int ISRC_PFT0 = 8;
   localparam int ISRC_STAR = 14;

   // Destination indices
   localparam int DST_AI_CONV   = 0;
   localparam int DST_AI_SAMP   = 1;
   localparam int DST_AI_START  = 2;
   localparam int DST_AI_REF    = 3;
   localparam int DST_AI_TB     = 4;
   localparam int DST_AO_START  = 5;
   localparam int DST_AO_SAMP   = 6;
   localparam int DST_AO_TB     = 7;
   localparam int DST_AO_PAUSE  = 8;
   localparam int DST_CTR0      = 9;
   localparam int DST_DI_SAMP   = 23;
   localparam int DST_DO_SAMP   = 24;

   localparam logic RST_USE_PLL  = 1'b0;
   localparam logic RST_OE_N     = 1'b1;

   typedef enum logic [1:0] {
      TBR_RUN,
      TBR_WAIT_OLD,
      TBR_WAIT_NEW
   } tbr_sw_e;

   typedef struct packed {
      logic [3:0] sel;
      logic       invert;
      logic       edge_mode;
   } tbr_dest_cfg_s;

   typedef struct packed {
      logic       en;
      logic [4:0] sel;
   } tbr_bus_cfg_s;

   typedef struct packed {
      logic t80;
      logic t20;
      logic t100k;
   } tbr_tick_s;

endpackage

// ### hw/tbr_sync.sv
`timescale 1ns/1ns
`default_nettype none
module tbr_sync
   import tbr_pkg::*;
#(
   parameter int W = 1
) (
   input  wire logic         ref_clk,
   input  wire logic         resetn,
   input  wire logic         ce,
   input  wire logic [W-1:0] pin,
   output logic      [W-1:0] q
);

   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic [W-1:0] s3;
      logic [W-1:0] q;
   } tbr_sync_st_s;

   tbr_sync_st_s r;
   tbr_sync_st_s nxt;

   // A bit moves only once the second and third stages agree
   always_comb begin
      nxt    = r;
      nxt.s1 = pin;
      nxt.s2 = r.s1;
      nxt.s3 = r.s2;
      nxt.q  = (r.s2 & r.s3) | (r.q & (r.s2 | r.s3));
   end

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         r <= '0;
      end else if (ce) begin
         r <= nxt;
      end
   end

   assign q = r.q;

endmodule
`default_nettype wire

// ### hw/tbr_div.sv
`timescale 1ns/1ns
`default_nettype none
module tbr_div
   import tbr_pkg::*;
#(
   parameter int RATIO = 4
) (
   input  wire logic ref_clk,
   input  wire logic resetn,
   input  wire logic ce,
   input  wire logic tick_in,
   output logic      tick_out,
   output logic      level
);

   localparam int CW = $clog2(RATIO);
   localparam logic [CW-1:0] LAST = CW'(RATIO - 1);
   localparam logic [CW-1:0] HALF = CW'(RATIO / 2);

   typedef struct packed {
      logic [CW-1:0] cnt;
      logic          tick;
      logic          level;
   } tbr_div_st_s;

   tbr_div_st_s r;
   tbr_div_st_s nxt;

   always_comb begin
      nxt      = r;
      nxt.tick = 1'b0;
      if (tick_in) begin
         if (r.cnt == LAST) begin
            nxt.cnt  = '0;
            nxt.tick = 1'b1;
         end else begin
            nxt.cnt = r.cnt + CW'(1);
         end
         // Square wave: high for the first half of each period
         nxt.level = (nxt.cnt < HALF);
      end
   end

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         r <= '0;
      end else if (ce) begin
         r <= nxt;
      end
   end

   assign tick_out = r.tick;
   assign level    = r.level;

endmodule
`default_nettype wire

// ### hw/tbr_top.sv
`timescale 1ns/1ns
`default_nettype none
module tbr_top
   import tbr_pkg::*;
(
   input  wire logic                          ref_clk,
   input  wire logic                          resetn,
   input  wire logic                          ce,
   // Pins from outside this clock domain
   input  wire logic                          osc_pin,
   input  wire logic                          pll_clk_pin,
   input  wire logic                          clk10_pin,
   input  wire logic                          star_pin,
   input  wire logic [PFT_LINES-1:0]          pft_i,
   input  wire logic [BUS_LINES-1:0]          bus_i,
   output logic      [BUS_LINES-1:0]          bus_o,
   output logic      [BUS_LINES-1:0]          bus_oe_n,
   // Onboard timing signals, same clock
   input  wire logic [NUM_SRC-1:0]            int_sig,
   // Configuration
   input  wire logic                          tb_src_pll,
   input  wire logic [3:0]                    ext_ref_sel,
   input  wire logic [NUM_CTR-1:0][1:0]       ctr_src_sel,
   input  wire logic                          ai_tb_slow,
   input  wire logic                          ao_tb_slow,
   input  wire tbr_bus_cfg_s [BUS_LINES-1:0]  bus_cfg,
   input  wire tbr_dest_cfg_s [NUM_DEST-1:0]  dest_cfg,
   // Results
   output logic                               pll_ref,
   output logic                               ref10_clk,
   output tbr_tick_s                          tb_tick,
   output logic      [NUM_CTR-1:0]            ctr_src_tick,
   output logic                               ai_timebase,
   output logic                               ao_timebase,
   output logic      [NUM_DEST-1:0]           dest_sig,
   output logic                               tb_on_pll,
   output logic                               tb_switching
);

   localparam int NPIN = 4 + PFT_LINES + BUS_LINES;

   typedef struct packed {
      tbr_sw_e                   sw;
      logic                      use_pll;
      logic                      osc_prev;
      logic                      pll_prev;
      logic                      tick80;
      logic                      switching;
      logic [NUM_CTR-1:0]        ctr_tick;
      logic                      ai_tb;
      logic                      ao_tb;
      logic                      pll_ref;
      logic [BUS_LINES-1:0]      bus_o;
      logic [BUS_LINES-1:0]      bus_oe_n;
      logic [NUM_DEST-1:0]       dest;
      logic [NUM_DEST-1:0]       prev;
   } tbr_top_st_s;

   tbr_top_st_s r;
   tbr_top_st_s nxt;

   logic [NPIN-1:0]      pin_s;
   logic                 osc_s;
   logic                 pll_s;
   logic                 clk10_s;
   logic                 star_s;
   logic [PFT_LINES-1:0] pft_s;
   logic [BUS_LINES-1:0] bus_s;
   logic                 t20;
   logic                 t100k;
   logic                 ref10;

   // All foreign-domain inputs share one synchroniser bank
   tbr_sync #(
      .W (NPIN)
   ) u_sync (
      .ref_clk (ref_clk),
      .resetn  (resetn),
      .ce      (ce),
      .pin     ({osc_pin, pll_clk_pin, clk10_pin, star_pin, pft_i, bus_i}),
      .q       (pin_s)
   );

   assign bus_s   = pin_s[BUS_LINES-1:0];
   assign pft_s   = pin_s[BUS_LINES +: PFT_LINES];
   assign star_s  = pin_s[BUS_LINES+PFT_LINES];
   assign clk10_s = pin_s[BUS_LINES+PFT_LINES+1];
   assign pll_s   = pin_s[BUS_LINES+PFT_LINES+2];
   assign osc_s   = pin_s[BUS_LINES+PFT_LINES+3];

   logic osc_edge;
   logic pll_edge;
   assign osc_edge = osc_s & ~r.osc_prev;
   assign pll_edge = pll_s & ~r.pll_prev;

   // 20 MHz from the master timebase
   tbr_div #(
      .RATIO (DIV_20M)
   ) u_div20 (
      .ref_clk  (ref_clk),
      .resetn   (resetn),
      .ce       (ce),
      .tick_in  (r.tick80),
      .tick_out (t20),
      .level    ()
   );

   // 100 kHz from the 20 MHz timebase
   tbr_div #(
      .RATIO (DIV_100K)
   ) u_div100k (
      .ref_clk  (ref_clk),
      .resetn   (resetn),
      .ce       (ce),
      .tick_in  (t20),
      .tick_out (t100k),
      .level    ()
   );

   // 10 MHz reference straight from the oscillator, whatever the timebase source
   tbr_div #(
      .RATIO (2 * REF10_HALF)
   ) u_div10 (
      .ref_clk  (ref_clk),
      .resetn   (resetn),
      .ce       (ce),
      .tick_in  (osc_edge),
      .tick_out (),
      .level    (ref10)
   );

   // Input source vector for the routing destinations
   logic [15:0] in_vec;
   // Output source vector toward the bus terminals
   logic [NUM_SRC-1:0] out_vec;

   always_comb begin
      in_vec = '0;
      in_vec[BUS_LINES-1:0] = bus_s;
      in_vec[ISRC_PFT0 +: PFT_LINES] = pft_s;
      in_vec[ISRC_STAR] = star_s;
   end

   always_comb begin
      out_vec = int_sig;
      out_vec[OSRC_REF10] = ref10;
      out_vec[OSRC_PFT0 +: PFT_LINES] = pft_s;
      // Convert and output sample clocks leave active low
      out_vec[OSRC_AI_CONV] = ~int_sig[OSRC_AI_CONV];
      out_vec[OSRC_AO_SAMP] = ~int_sig[OSRC_AO_SAMP];
   end

   always_comb begin
      logic raw;
      logic old_edge;
      logic new_edge;
      raw      = 1'b0;
      nxt      = r;
      nxt.osc_prev = osc_s;
      nxt.pll_prev = pll_s;
      old_edge = r.use_pll ? pll_edge : osc_edge;
      new_edge = r.use_pll ? osc_edge : pll_edge;

      // Master timebase with break-before-make switching
      nxt.tick80    = 1'b0;
      nxt.switching = 1'b0;
      case (r.sw)
         TBR_RUN: begin
            nxt.tick80 = old_edge;
            if (tb_src_pll != r.use_pll) begin
               nxt.sw        = TBR_WAIT_OLD;
               nxt.switching = 1'b1;
            end
         end
         TBR_WAIT_OLD: begin
            // Let the old source finish its current period, then mute
            nxt.switching = 1'b1;
            nxt.tick80    = old_edge;
            if (old_edge) begin
               nxt.sw = TBR_WAIT_NEW;
            end
         end
         TBR_WAIT_NEW: begin
            nxt.switching = 1'b1;
            // A new edge right behind the last old tick would make a runt; take the next one
            if (new_edge && !r.tick80) begin
               nxt.tick80  = 1'b1;
               nxt.use_pll = ~r.use_pll;
               nxt.sw      = TBR_RUN;
               nxt.switching = 1'b0;
            end
         end
         default: begin
            nxt.sw = TBR_RUN;
         end
      endcase

      // Reference for the external loop; the loop output returns on its pin
      case (ext_ref_sel)
         EXT_CLK10: nxt.pll_ref = clk10_s;
         EXT_STAR:  nxt.pll_ref = star_s;
         default: begin
            if (ext_ref_sel < EXT_CLK10) begin
               nxt.pll_ref = bus_s[ext_ref_sel[2:0]];
            end else begin
               nxt.pll_ref = 1'b0;
            end
         end
      endcase

      // Counter sources
      for (int c = 0; c < NUM_CTR; c++) begin
         case (ctr_src_sel[c])
            CSRC_80M:  nxt.ctr_tick[c] = r.tick80;
            CSRC_20M:  nxt.ctr_tick[c] = t20;
            CSRC_100K: nxt.ctr_tick[c] = t100k;
            default:   nxt.ctr_tick[c] = 1'b0;
         endcase
      end

      // Analog timebases
      nxt.ai_tb = ai_tb_slow ? t100k : t20;
      nxt.ao_tb = ao_tb_slow ? t100k : t20;

      // Bus terminals: drive when enabled, otherwise release
      for (int b = 0; b < BUS_LINES; b++) begin
         nxt.bus_oe_n[b] = ~bus_cfg[b].en;
         if (int'(bus_cfg[b].sel) < NUM_SRC) begin
            nxt.bus_o[b] = out_vec[bus_cfg[b].sel];
         end else begin
            nxt.bus_o[b] = 1'b0;
         end
      end

      // Destinations: polarity, then level or rising edge
      for (int d = 0; d < NUM_DEST; d++) begin
         raw = in_vec[dest_cfg[d].sel] ^ dest_cfg[d].invert;
         nxt.prev[d] = raw;
         if (dest_cfg[d].edge_mode) begin
            nxt.dest[d] = raw & ~r.prev[d];
         end else begin
            nxt.dest[d] = raw;
         end
      end
   end

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         r          <= '0;
         r.sw       <= TBR_RUN;
         r.use_pll  <= RST_USE_PLL;
         r.bus_oe_n <= {BUS_LINES{RST_OE_N}};
      end else if (ce) begin
         r <= nxt;
      end
   end

   assign bus_o        = r.bus_o;
   assign bus_oe_n     = r.bus_oe_n;
   assign pll_ref      = r.pll_ref;
   assign ref10_clk    = ref10;
   assign tb_tick      = '{t80: r.tick80, t20: t20, t100k: t100k};
   assign ctr_src_tick = r.ctr_tick;
   assign ai_timebase  = r.ai_tb;
   assign ao_timebase  = r.ao_tb;
   // Start trigger destinations are where a shared bus trigger lands
   assign dest_sig     = r.dest;
   assign tb_on_pll    = r.use_pll;
   assign tb_switching = r.switching;

endmodule
`default_nettype wire

// ### testbench/tbr_props.sv
`timescale 1ns/1ns
`default_nettype none
module tbr_props
   import tbr_pkg::*;
(
   input wire logic                         ref_clk,
   input wire logic                         resetn,
   input wire logic                         ce,
   input wire logic [NUM_SRC-1:0]           int_sig,
   input wire logic                         tb_src_pll,
   input wire logic [NUM_CTR-1:0][1:0]      ctr_src_sel,
   input wire tbr_bus_cfg_s [BUS_LINES-1:0] bus_cfg,
   input wire logic [BUS_LINES-1:0]         bus_o,
   input wire logic [BUS_LINES-1:0]         bus_oe_n,
   input wire tbr_tick_s                    tb_tick,
   input wire logic [NUM_CTR-1:0]           ctr_src_tick,
   input wire logic                         tb_on_pll,
   input wire logic                         tb_switching
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!resetn || !ce);

   logic [2:0]           n80_r;
   logic [7:0]           n20_r;
   logic [BUS_LINES-1:0] en;

   always_comb begin
      for (int i = 0; i < BUS_LINES; i++) begin
         en[i] = bus_cfg[i].en;
      end
   end

   // Ticks since the last slower tick; a frozen enable must not count twice
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         n80_r <= 3'h0;
         n20_r <= 8'h00;
      end else if (ce) begin
         n80_r <= tb_tick.t20 ? 3'(tb_tick.t80) : n80_r + 3'(tb_tick.t80);
         n20_r <= tb_tick.t100k ? 8'(tb_tick.t20) : n20_r + 8'(tb_tick.t20);
      end
   end

   t20_ratio_a: assert property (tb_tick.t20 |-> n80_r == 3'h4)
      else $error("t20 tick not after four t80 ticks");
   t100k_ratio_a: assert property (tb_tick.t100k |-> n20_r == 8'hC8)
      else $error("t100k tick not after 200 t20 ticks");
   no_runt_a: assert property (tb_tick.t80 |=> !tb_tick.t80)
      else $error("t80 ticks back to back");
   reset_state_a: assert property ($rose(resetn) |-> bus_oe_n == 8'hFF && !tb_on_pll)
      else $error("outputs not in reset state after release");
   oe_follows_a: assert property ($past(resetn) |-> bus_oe_n == ~$past(en))
      else $error("bus enable does not follow config");
   conv_inverted_a: assert property ($past(en[0] && bus_cfg[0].sel == OSRC_AI_CONV)
      |-> bus_o[0] == !$past(int_sig[OSRC_AI_CONV])) else $error("convert clock not inverted");
   samp_inverted_a: assert property ($past(en[1] && bus_cfg[1].sel == OSRC_AO_SAMP)
      |-> bus_o[1] == !$past(int_sig[OSRC_AO_SAMP])) else $error("sample clock not inverted");
   plain_route_a: assert property ($past(en[0] && bus_cfg[0].sel == OSRC_AI_START)
      |-> bus_o[0] == $past(int_sig[OSRC_AI_START])) else $error("start trigger not passed");
   switch_start_a: assert property ($changed(tb_src_pll) && !tb_switching
      && tb_src_pll != tb_on_pll |-> ##[1:2] tb_switching) else $error("switch not started");
   switch_bound_a: assert property ($rose(tb_switching) |-> ##[1:200] !tb_switching)
      else $error("source switch hangs");
   switch_done_a: assert property ($fell(tb_switching) |-> $changed(tb_on_pll))
      else $error("switch ended without source change");
   ctr_slow_a: assert property (ctr_src_tick[1] && ctr_src_sel[1] == CSRC_100K
      && $past(ctr_src_sel[1]) == CSRC_100K |-> tb_tick.t100k || $past(tb_tick.t100k))
      else $error("counter tick without 100k tick");
   ctr_none_a: assert property (ctr_src_sel[1] == 2'h3 && $past(ctr_src_sel[1]) == 2'h3
      |-> !ctr_src_tick[1]) else $error("counter tick with no source");

   cover property ($rose(tb_switching));
   cover property (tb_tick.t100k);
   cover property ($past(en[0] && bus_cfg[0].sel == OSRC_AI_CONV));
endmodule
`default_nettype wire

// ### testbench/tbr_far_end.sv
`timescale 1ns/1ns
`default_nettype none
module tbr_far_end
   import tbr_pkg::*;
#(
   parameter int OSC_HALF  = 20,
   parameter int PLL_HALF  = 22,
   parameter int C10_HALF  = 60,
   parameter int STAR_HALF = 100
) (
   input  wire logic                 star_run,
   input  wire logic [BUS_LINES-1:0] ext_oe,
   input  wire logic [BUS_LINES-1:0] ext_val,
   input  wire logic [BUS_LINES-1:0] bus_o,
   input  wire logic [BUS_LINES-1:0] bus_oe_n,
   output logic                      osc_pin,
   output logic                      pll_clk_pin,
   output logic                      clk10_pin,
   output logic                      star_pin,
   output logic      [BUS_LINES-1:0] bus_i
);
   // Rates scaled down so each phase spans several sampling edges
   initial begin
      osc_pin = 1'b0;
      pll_clk_pin = 1'b0;
      clk10_pin = 1'b0;
      star_pin = 1'b0;
   end
   always #OSC_HALF osc_pin = !osc_pin;
   always #PLL_HALF pll_clk_pin = !pll_clk_pin;
   always #C10_HALF clk10_pin = !clk10_pin;
   always #STAR_HALF star_pin = star_run ? !star_pin : 1'b0;

   // Released lines fall to the pull-down; two drivers give an unknown
   always_comb begin
      for (int i = 0; i < BUS_LINES; i++) begin
         if (!bus_oe_n[i] && ext_oe[i]) begin
            bus_i[i] = 1'bx;
         end else begin
            bus_i[i] = !bus_oe_n[i] ? bus_o[i] : ext_oe[i] && ext_val[i];
         end
      end
   end
endmodule
`default_nettype wire

// ### testbench/testbench.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin error_cnt++; \
   $display("[FAIL] %s exp %0h got %0h", nm, e, g); end end
module testbench
   import tbr_pkg::*;
;
   typedef struct packed {
      logic [2:0] line;
      logic [4:0] src;
      logic [4:0] dst;
      logic       dinv;
   } tbr_row_s;
   localparam tbr_row_s ROWS [13] = '{
      '{3'h0, 5'h02, 5'h00, 1'b0}, '{3'h1, 5'h04, 5'h01, 1'b1}, '{3'h0, 5'h00, 5'h02, 1'b0},
      '{3'h3, 5'h01, 5'h03, 1'b1}, '{3'h4, 5'h03, 5'h04, 1'b0}, '{3'h5, 5'h05, 5'h05, 1'b0},
      '{3'h6, 5'h06, 5'h06, 1'b1}, '{3'h7, 5'h08, 5'h07, 1'b0}, '{3'h2, 5'h10, 5'h08, 1'b1},
      '{3'h1, 5'h11, 5'h09, 1'b0}, '{3'h2, 5'h12, 5'h17, 1'b0}, '{3'h3, 5'h13, 5'h18, 1'b1},
      '{3'h7, 5'h18, 5'h0A, 1'b0}};

   logic                         ref_clk = 1'b0;
   logic                         resetn, ce, tb_src_pll, ai_tb_slow, ao_tb_slow, star_run;
   logic                         osc_pin, pll_clk_pin, clk10_pin, star_pin, cnt_en;
   logic                         pll_ref, ref10_clk, ai_timebase, ao_timebase;
   logic                         tb_on_pll, tb_switching, r10_q, prf_q;
   logic [3:0]                   ext_ref_sel;
   logic [PFT_LINES-1:0]         pft_i;
   logic [BUS_LINES-1:0]         bus_i, bus_o, bus_oe_n, ext_oe, ext_val;
   logic [NUM_SRC-1:0]           int_sig;
   logic [NUM_CTR-1:0][1:0]      ctr_src_sel;
   logic [NUM_CTR-1:0]           ctr_src_tick;
   logic [NUM_DEST-1:0]          dest_sig;
   tbr_bus_cfg_s [BUS_LINES-1:0] bus_cfg;
   tbr_dest_cfg_s [NUM_DEST-1:0] dest_cfg;
   tbr_tick_s                    tb_tick;
   int                           error_cnt = 0;
   int                           tests_run = 0;
   int                           n [9];

   tbr_top u_tbr_top (.ref_clk, .resetn, .ce, .osc_pin, .pll_clk_pin, .clk10_pin, .star_pin,
      .pft_i, .bus_i, .bus_o, .bus_oe_n, .int_sig, .tb_src_pll, .ext_ref_sel, .ctr_src_sel,
      .ai_tb_slow, .ao_tb_slow, .bus_cfg, .dest_cfg, .pll_ref, .ref10_clk, .tb_tick,
      .ctr_src_tick, .ai_timebase, .ao_timebase, .dest_sig, .tb_on_pll, .tb_switching);
   tbr_far_end u_tbr_far_end (.star_run, .ext_oe, .ext_val, .bus_o, .bus_oe_n, .osc_pin,
      .pll_clk_pin, .clk10_pin, .star_pin, .bus_i);

   always #2 ref_clk = !ref_clk;

   always @(posedge ref_clk) begin
      if (cnt_en) begin
         n[0] += tb_tick.t80;
         n[1] += tb_tick.t20;
         n[2] += tb_tick.t100k;
         n[3] += ai_timebase;
         n[4] += ao_timebase;
         n[5] += ctr_src_tick[0];
         n[6] += ctr_src_tick[1];
         n[7] += ref10_clk && !r10_q;
         n[8] += pll_ref && !prf_q;
      end
      r10_q <= ref10_clk;
      prf_q <= pll_ref;
   end

   task automatic cyc(input int k);
      repeat (k) @(posedge ref_clk);
   endtask

   task automatic win(input int k);
      @(posedge ref_clk);
      n = '{default: 0};
      cnt_en <= 1'b1;
      cyc(k);
      cnt_en <= 1'b0;
      @(negedge ref_clk);
   endtask

   // Window edges may clip one tick either way
   function automatic logic near(input int a, input int b);
      return 1'(a >= b - 1 && a <= b + 1);
   endfunction

   task automatic swap(input logic p);
      int k;
      @(posedge ref_clk);
      tb_src_pll <= p;
      for (k = 0; k < 100 && tb_on_pll !== p; k++) @(negedge ref_clk);
      `CHK("tb_on_pll", p, tb_on_pll)
   endtask

   task automatic results();
      $display("checks %0d errors %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask

   initial begin
      tbr_row_s                     x;
      tbr_bus_cfg_s [BUS_LINES-1:0] bc;
      tbr_dest_cfg_s [NUM_DEST-1:0] dc;
      logic                         e;
      int                           hi;
      {resetn, tb_src_pll, ai_tb_slow, ao_tb_slow, star_run, cnt_en} = '0;
      {ext_ref_sel, pft_i, ext_oe, ext_val, int_sig, ctr_src_sel, bus_cfg} = '0;
      ce = 1'b1;
      dest_cfg = {NUM_DEST{6'h3C}};
      cyc(19);
      @(negedge ref_clk);
      `CHK("rst bus_oe_n", 8'hFF, bus_oe_n)
      `CHK("rst tb_on_pll", 1'b0, tb_on_pll)
      @(posedge ref_clk);
      resetn <= 1'b1;
      foreach (ROWS[r]) for (int v = 0; v < 2; v++) begin
         x = ROWS[r];
         bc = '0;
         bc[x.line] = '{1'b1, x.src};
         dc = {NUM_DEST{6'h3C}};
         dc[x.dst] = '{{1'b0, x.line}, x.dinv, 1'b0};
         e = v[0] ^ (x.src == 5'h02 || x.src == 5'h04);
         @(posedge ref_clk);
         bus_cfg <= bc;
         dest_cfg <= dc;
         int_sig <= {NUM_SRC{~v[0]}} ^ (NUM_SRC'(1) << x.src);
         pft_i <= {PFT_LINES{~v[0]}} ^ (PFT_LINES'(1) << (x.src - 5'h13));
         cyc(16);
         @(negedge ref_clk);
         `CHK("bus_oe_n", ~(8'h01 << x.line), bus_oe_n)
         `CHK("bus_o", e, bus_o[x.line])
         `CHK("dest_sig", e ^ x.dinv, dest_sig[x.dst])
      end
      @(posedge ref_clk);
      bus_cfg <= '0;
      ctr_src_sel <= {CSRC_100K, CSRC_80M};
      ao_tb_slow <= 1'b1;
      win(8400);
      `CHK("t80", 1'b1, near(n[0], 840))
      `CHK("t20", 1'b1, near(n[1], n[0] / 4))
      `CHK("t100k", 1'b1, n[2] inside {[1:2]})
      `CHK("ai_tb", 1'b1, near(n[3], n[1]))
      `CHK("ao_tb", n[2], n[4])
      `CHK("ctr0", 1'b1, near(n[5], n[0]))
      `CHK("ctr1", n[2], n[6])
      `CHK("ref10", 1'b1, near(n[7], 105))
      @(posedge ref_clk);
      bus_cfg[3] <= '{1'b1, 5'(OSRC_REF10)};
      ext_ref_sel <= 4'h3;
      ctr_src_sel <= {2'h3, CSRC_20M};
      ai_tb_slow <= 1'b1;
      swap(1'b1);
      win(9600);
      `CHK("pll t80", 1'b1, near(n[0], 873))
      `CHK("pll ref10", 1'b1, near(n[7], 120))
      `CHK("pll_ref", 1'b1, near(n[8], n[7]))
      `CHK("ai slow", n[2], n[3])
      `CHK("ctr0 20M", 1'b1, near(n[5], n[1]))
      `CHK("ctr1 none", 0, n[6])
      for (int s = 8; s < 10; s++) begin
         @(posedge ref_clk);
         ext_ref_sel <= 4'(s);
         star_run <= (s == 9);
         cyc(20);
         win(1200);
         `CHK("ext ref", 1'b1, near(n[8], s == 8 ? 40 : 24))
      end
      @(posedge ref_clk);
      star_run <= 1'b0;
      ext_oe <= 8'h20;
      dest_cfg[DST_AI_START] <= '{4'h5, 1'b0, 1'b1};
      cyc(12);
      ext_val <= 8'h20;
      hi = 0;
      repeat (30) begin
         @(negedge ref_clk);
         hi += dest_sig[DST_AI_START];
      end
      `CHK("edge pulse", 1, hi)
      @(posedge ref_clk);
      ce <= 1'b0;
      win(200);
      `CHK("ce freeze", 0, n[7])
      @(posedge ref_clk);
      ce <= 1'b1;
      swap(1'b0);
      results();
   end

   // About 21k cycles are expected; more than twice that means a hang
   initial begin
      cyc(50000);
      error_cnt++;
      results();
   end
endmodule
bind tbr_top tbr_props u_tbr_props (.ref_clk, .resetn, .ce, .int_sig, .tb_src_pll,
   .ctr_src_sel, .bus_cfg, .bus_o, .bus_oe_n, .tb_tick, .ctr_src_tick, .tb_on_pll,
   .tb_switching);
`default_nettype wire
